/* scpc_pkg.sv */
package scpc_pkg;
	// ------------------------------------------------------------
	// register map (serial port addresses)
	// ------------------------------------------------------------
	localparam logic [12:0] ADDR_DIVIDE_RATIO   = 13'h008;
	localparam logic [12:0] ADDR_CLOCK_INPUT    = 13'h009;
	localparam logic [12:0] ADDR_RESYNC_CONTROL = 13'h03A;
	localparam logic [12:0] ADDR_STABILIZER_EN  = 13'h00B;
	localparam logic [12:0] ADDR_POWER_MODE     = 13'h00C;
	localparam logic [12:0] ADDR_CLOCK_STATUS   = 13'h00D;

	// field positions
	localparam int RATIO_LSB     = 0;
	localparam int HF_SEL_BIT    = 0;
	localparam int RESYNC_EVERY  = 1;
	localparam int RESYNC_ONCE   = 2;
	localparam int STAB_EN_BIT   = 0;
	localparam int PMODE_LSB     = 0;

	// reset values
	localparam logic [2:0] RATIO_M1_RST = 3'h0;
	localparam logic       HF_SEL_RST   = 1'h0;
	localparam logic       STAB_EN_RST  = 1'h1;

	// power modes
	typedef enum logic [1:0] {
		SCPC_PM_NORMAL  = 2'b00,
		SCPC_PM_PWRDOWN = 2'b01,
		SCPC_PM_STANDBY = 2'b10
	} scpc_pmode_t;

	// serial frame: 16 instruction bits then 8 data bits
	localparam logic [4:0] SPI_INSTR_LAST = 5'h0F;
	localparam logic [4:0] SPI_DATA_LAST  = 5'h17;
	localparam logic [4:0] SPI_DONE       = 5'h18;
	localparam int         SPI_RW_BIT     = 15;

	// timing
	localparam int CLK_PERIOD_PS     = 10000;
	localparam int STAB_MIN_RATE_KHZ = 40000;
	localparam int STAB_MIN_PER_PS   = 1000000000 / STAB_MIN_RATE_KHZ;
	// longest input period the stabilizer still follows, rounded down
	localparam int STAB_MAX_PER_CYC  = (STAB_MIN_PER_PS / CLK_PERIOD_PS) < 1
		? 1 : STAB_MIN_PER_PS / CLK_PERIOD_PS;
	localparam logic [1:0] HF_PRESCALE_LAST = 2'h3;   // divide by four
	localparam logic [2:0] LOCK_EDGES       = 3'h4;
	localparam int         WAKE_SHIFT       = 2;
	localparam int         STBY_SHIFT       = 4;
endpackage

/* scpc_sync.sv */
`timescale 1ns/10ps
// two flip-flop synchroniser for a group of pins
module scpc_sync
#(
	parameter int W = 1
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= '0;
			dout <= '0;
		end
		else
		begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

/* scpc_top.sv */
`timescale 1ns/10ps
// Functional notes
// - selected clock divided by integer ratio 1 to 8 for conversion
// - high-frequency input first divided by four, then by the divider
// - 0x09 picks high-frequency input; 0x08 ratio serves both paths
// - stabilizer forced on whenever divide ratio is not 1
// - 0x3A bits choose resync on every strobe or first after write
// - accepted reference strobe returns divider to its initial state
// - locked stabilizer regenerates falling edge for 50% duty
// - stabilizer treated as non-functional below about 40 MHz input
// - unlocked stabilizer is bypassed; divider output passes through (Nyquist input duty only at ratio 1)
// - power-down by pin high or serial control; pin low resumes
// - power-down turns off reference, buffer, bias and clock
// - wake-up delay scales with time spent powered down
// - serial standby keeps reference powered for faster wake-up
// - after reset the differential Nyquist input is selected
module scpc_top
	import scpc_pkg::*;
#(
	parameter int PD_TIME_W = 16
)
(
	input  wire logic CLK_SYS,
	input  wire logic ARST_N,
	input  wire logic NYQ_CLK,
	input  wire logic HIGH_FREQ_CLOCK_INPUT,
	input  wire logic SYSREF,
	input  wire logic POWER_DOWN_REQUEST,
	input  wire logic SCLK,
	input  wire logic CSB_N,
	input  wire logic SDIO_I,
	output logic      SDIO_O,
	output logic      SDIO_OE,
	output logic      CONV_CLK,
	output logic      REF_ON,
	output logic      BIAS_ON,
	output logic      CLK_ON,
	output logic      READY,
	output logic      STAB_LOCKED
);
	typedef struct packed {
		logic [4:0]           spi_cnt;
		logic [15:0]          spi_shift;
		logic                 spi_rd;
		logic [12:0]          spi_addr;
		logic [7:0]           sdo_buf;
		logic                 sdo;
		logic                 sdo_oe;
		logic [2:0]           ratio_m1;
		logic                 hf_sel;
		logic                 resync_every;
		logic                 resync_once;
		logic                 stab_en;
		scpc_pmode_t          pmode;
		logic                 sclk_q;
		logic                 nyq_q;
		logic                 hf_q;
		logic                 sysref_q;
		logic [1:0]           pre_cnt;
		logic [2:0]           div_cnt;
		logic [2:0]           div_m1;
		logic [7:0]           in_per;
		logic                 in_slow;
		logic [7:0]           tick_per;
		logic [7:0]           tick_last;
		logic [2:0]           lock_cnt;
		logic                 locked;
		logic [7:0]           hi_cnt;
		logic                 regen;
		logic                 conv;
		logic [PD_TIME_W-1:0] pd_time;
		logic [PD_TIME_W-1:0] wake_cnt;
		logic                 down_q;
		logic                 ready;
		logic                 ref_on;
		logic                 bias_on;
		logic                 clk_on;
	} scpc_state_t;

	scpc_state_t st;
	scpc_state_t next_st;
	logic [1:0]  rst_pipe;
	logic        rst_n;
	logic [6:0]  pin_s;
	logic        nyq_s, hf_s, sysref_s, pdpin_s, sclk_s, csb_s, sdi_s;
	// intermediate terms of the next-state logic
	logic        sclk_rise, sclk_fall, nyq_rise, hf_rise, sref_rise;
	logic        in_rise, restart, tick, stab_act, base, raw;
	logic        pd_req, stby, down;
	logic [15:0] instr;
	logic [7:0]  wdata, rdata;
	logic [12:0] addr;

	// ------------------------------------------------------------
	// reset release and pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_n = rst_pipe[1];

	scpc_sync #(.W(7)) u_sync (
		.clk  (CLK_SYS),
		.rst_n(rst_n),
		.din  ({NYQ_CLK, HIGH_FREQ_CLOCK_INPUT, SYSREF,
			POWER_DOWN_REQUEST, SCLK, CSB_N, SDIO_I}),
		.dout (pin_s)
	);
	assign {nyq_s, hf_s, sysref_s, pdpin_s, sclk_s, csb_s, sdi_s} = pin_s;

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		next_st   = st;
		sclk_rise = sclk_s & ~st.sclk_q;
		sclk_fall = ~sclk_s & st.sclk_q;
		nyq_rise  = nyq_s & ~st.nyq_q;
		hf_rise   = hf_s & ~st.hf_q;
		sref_rise = sysref_s & ~st.sysref_q;
		instr     = {st.spi_shift[14:0], sdi_s};
		wdata     = instr[7:0];
		addr      = st.spi_addr;
		next_st.sclk_q   = sclk_s;
		next_st.nyq_q    = nyq_s;
		next_st.hf_q     = hf_s;
		next_st.sysref_q = sysref_s;

		// read data mux
		case (instr[12:0])
			ADDR_DIVIDE_RATIO:   rdata = {5'h00, st.ratio_m1};
			ADDR_CLOCK_INPUT:    rdata = {7'h00, st.hf_sel};
			ADDR_RESYNC_CONTROL: rdata = {5'h00, st.resync_once,
				st.resync_every, 1'b0};
			ADDR_STABILIZER_EN:  rdata = {7'h00, st.stab_en};
			ADDR_POWER_MODE:     rdata = {6'h00, st.pmode};
			ADDR_CLOCK_STATUS:   rdata = {4'h0, st.ready, st.in_slow,
				st.locked, st.ratio_m1 != RATIO_M1_RST || st.stab_en};
			default:             rdata = 8'h00;
		endcase

		// input path: prescaler on the high-frequency pin
		if (hf_rise)
			next_st.pre_cnt = st.pre_cnt + 2'h1;
		in_rise = st.hf_sel ? (hf_rise && st.pre_cnt == HF_PRESCALE_LAST)
			: nyq_rise;
		base = st.hf_sel ? ~st.pre_cnt[1] : nyq_s;

		// reference strobe accepted per policy
		restart = sref_rise && (st.resync_every || st.resync_once);
		if (restart)
			next_st.resync_once = 1'b0;

		// integer divider
		tick = 1'b0;
		if (restart)
		begin
			next_st.div_cnt = 3'h0;
			next_st.div_m1  = st.ratio_m1;
		end
		else if (in_rise)
		begin
			if (st.div_cnt >= st.div_m1)
			begin
				next_st.div_cnt = 3'h0;
				next_st.div_m1  = st.ratio_m1;
				tick            = 1'b1;
			end
			else
				next_st.div_cnt = st.div_cnt + 3'h1;
		end
		raw = (st.div_m1 == RATIO_M1_RST) ? base
			: (st.div_cnt <= (st.div_m1 >> 1));

		// input period watch for the slow-clock limit
		if (in_rise)
		begin
			next_st.in_per  = 8'h01;
			next_st.in_slow = st.in_per > 8'(STAB_MAX_PER_CYC);
		end
		else if (st.in_per != 8'hFF)
			next_st.in_per = st.in_per + 8'h01;

		// stabilizer: period lock and falling-edge regeneration
		stab_act = st.stab_en || st.ratio_m1 != RATIO_M1_RST;
		if (st.tick_per != 8'hFF)
			next_st.tick_per = st.tick_per + 8'h01;
		if (st.hi_cnt != 8'hFF)
			next_st.hi_cnt = st.hi_cnt + 8'h01;
		if (st.regen && st.hi_cnt + 8'h01 >= (st.tick_last >> 1))
			next_st.regen = 1'b0;
		if (tick)
		begin
			next_st.tick_per  = 8'h01;
			next_st.tick_last = st.tick_per;
			next_st.regen     = 1'b1;
			next_st.hi_cnt    = 8'h00;
			if (st.tick_per == st.tick_last && !st.in_slow)
			begin
				if (st.lock_cnt != LOCK_EDGES)
					next_st.lock_cnt = st.lock_cnt + 3'h1;
			end
			else
				next_st.lock_cnt = 3'h0;
		end
		if (restart || st.in_slow || !stab_act)
			next_st.lock_cnt = 3'h0;
		next_st.locked = next_st.lock_cnt == LOCK_EDGES;

		// power control
		pd_req = pdpin_s || st.pmode == SCPC_PM_PWRDOWN;
		stby   = !pd_req && st.pmode == SCPC_PM_STANDBY;
		down   = pd_req || stby;
		next_st.down_q  = down;
		next_st.ref_on  = !pd_req;
		next_st.bias_on = !down;
		next_st.clk_on  = !down;
		if (down)
		begin
			next_st.ready    = 1'b0;
			next_st.wake_cnt = '0;
			if (st.pd_time != '1)
				next_st.pd_time = st.pd_time + 1'b1;
		end
		else if (st.down_q)
		begin
			next_st.wake_cnt = st.ref_on
				? (st.pd_time >> STBY_SHIFT) : (st.pd_time >> WAKE_SHIFT);
			next_st.pd_time  = '0;
		end
		else if (st.wake_cnt != '0)
			next_st.wake_cnt = st.wake_cnt - 1'b1;
		else
			next_st.ready = 1'b1;

		// conversion clock: regenerated when locked, else bypass
		case (down)
			1'b1:    next_st.conv = 1'b0;
			default: next_st.conv = (stab_act && st.locked)
				? next_st.regen : raw;
		endcase

		// serial port slave
		if (csb_s)
		begin
			next_st.spi_cnt = 5'h00;
			next_st.sdo_oe  = 1'b0;
			next_st.spi_rd  = 1'b0;
		end
		else if (sclk_rise && st.spi_cnt != SPI_DONE)
		begin
			next_st.spi_shift = instr;
			next_st.spi_cnt   = st.spi_cnt + 5'h01;
			if (st.spi_cnt == SPI_INSTR_LAST)
			begin
				next_st.spi_rd   = instr[SPI_RW_BIT];
				next_st.spi_addr = instr[12:0];
				next_st.sdo_buf  = rdata;
			end
			if (st.spi_cnt == SPI_DATA_LAST && !st.spi_rd)
			begin
				case (addr)
					ADDR_DIVIDE_RATIO:
						next_st.ratio_m1 = wdata[RATIO_LSB +: 3];
					ADDR_CLOCK_INPUT:
						next_st.hf_sel = wdata[HF_SEL_BIT];
					ADDR_RESYNC_CONTROL:
					begin
						next_st.resync_every = wdata[RESYNC_EVERY];
						next_st.resync_once  = wdata[RESYNC_ONCE];
					end
					ADDR_STABILIZER_EN:
						next_st.stab_en = wdata[STAB_EN_BIT];
					ADDR_POWER_MODE:
						next_st.pmode = scpc_pmode_t'(wdata[PMODE_LSB +: 2]);
					default: ;
				endcase
			end
		end
		else if (sclk_fall && st.spi_rd && st.spi_cnt != SPI_DONE)
		begin
			next_st.sdo_oe  = 1'b1;
			next_st.sdo     = st.sdo_buf[7];
			next_st.sdo_buf = {st.sdo_buf[6:0], 1'b0};
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st          <= '0;
			st.ratio_m1 <= RATIO_M1_RST;
			st.hf_sel   <= HF_SEL_RST;
			st.stab_en  <= STAB_EN_RST;
			st.pmode    <= SCPC_PM_NORMAL;
		end
		else
			st <= next_st;
	end

	assign SDIO_O      = st.sdo;
	assign SDIO_OE     = st.sdo_oe;
	assign CONV_CLK    = st.conv;
	assign REF_ON      = st.ref_on;
	assign BIAS_ON     = st.bias_on;
	assign CLK_ON      = st.clk_on;
	assign READY       = st.ready;
	assign STAB_LOCKED = st.locked;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!rst_n);

	ratio_reset_a: assert property ($rose(rst_n) |-> !st.hf_sel
		&& st.ratio_m1 == RATIO_M1_RST && st.stab_en)
		else $error("reset defaults not applied");
	conv_off_pd_a: assert property (pdpin_s |=> !CONV_CLK && !CLK_ON)
		else $error("clock still running in power-down");
	ref_off_pd_a: assert property (pdpin_s |=> !REF_ON && !BIAS_ON)
		else $error("reference still on in power-down");
	stby_ref_a: assert property (
		!pdpin_s && st.pmode == SCPC_PM_STANDBY |=> REF_ON && !BIAS_ON)
		else $error("standby did not keep reference");
	resync_div_a: assert property (
		$rose(sysref_s) && st.resync_every |=> st.div_cnt == 3'h0)
		else $error("divider not reset by strobe");
	once_clear_a: assert property (
		$rose(sysref_s) && st.resync_once && !(sclk_s && !st.sclk_q)
		|=> !st.resync_once)
		else $error("one-shot resync not consumed");
	div_bound_a: assert property (
		st.div_cnt <= st.div_m1 || $past(st.div_m1) != st.div_m1)
		else $error("divider count above ratio");
	stab_force_a: assert property (
		st.ratio_m1 != RATIO_M1_RST && st.in_slow |=> st.lock_cnt == 3'h0)
		else $error("stabilizer locked on slow clock");
	hf_prescale_a: assert property (
		st.hf_sel && $past(st.hf_sel) && $changed(st.div_cnt)
		&& !$past(sysref_s && !st.sysref_q)
		|-> $past(st.pre_cnt) == HF_PRESCALE_LAST)
		else $error("divider advanced off prescaler boundary");
	wake_wait_a: assert property (
		$fell(st.down_q)
		&& $past(st.pd_time) >= (PD_TIME_W'(1) << (STBY_SHIFT + 1))
		|=> !READY [*2])
		else $error("woke without delay");
	lock_flag_a: assert property (
		$past(STAB_LOCKED && (st.stab_en || st.ratio_m1 != RATIO_M1_RST))
		&& !st.down_q |-> CONV_CLK == st.regen)
		else $error("locked clock not regenerated");
endmodule

/* scpc_clk_src.sv */
`timescale 1ns/10ps
// far side: sample clock source and system reference generator
module scpc_clk_src
(
	input  wire logic       sysref_go,
	input  wire logic [7:0] half_ns,
	output logic            nyq_clk,
	output logic            hf_clk,
	output logic            sysref
);
	// --------------------------------
	// free-running clocks
	// --------------------------------
	// offset start keeps pin edges away from the system clock edge
	initial
	begin
		nyq_clk = 1'b0;
		hf_clk  = 1'b0;
		sysref  = 1'b0;
		#2;
		forever
		begin
			#(half_ns);
			nyq_clk = ~nyq_clk;
			hf_clk  = ~hf_clk;
		end
	end

	// strobe launched on a falling sample edge, one period wide
	always @(posedge sysref_go)
	begin
		@(negedge nyq_clk);
		sysref = 1'b1;
		@(negedge nyq_clk);
		sysref = 1'b0;
	end
endmodule

/* scpc_top_tb.sv */
`timescale 1ns/10ps
module scpc_top_tb import scpc_pkg::*;;
	logic        clk, arst_n, sclk, csb_n, sdio_drv, pd_pin, go;
	logic        sdio_o, sdio_oe, conv, ref_on, bias_on, clk_on;
	logic        ready, locked, nyq, hf, sysref;
	logic [7:0]  half_ns, q;
	logic [31:0] seed;
	int          err_total, checks, n, k1, k2, r, w, d, i;
	int          mdl [int];
	wire         sdio = sdio_oe ? sdio_o : sdio_drv;

	// --------------------------------
	// design and far side
	// --------------------------------
	scpc_top #(.PD_TIME_W(10)) u_scpc_top (.CLK_SYS(clk), .ARST_N(arst_n),
		.NYQ_CLK(nyq), .HIGH_FREQ_CLOCK_INPUT(hf), .SYSREF(sysref),
		.POWER_DOWN_REQUEST(pd_pin), .SCLK(sclk), .CSB_N(csb_n),
		.SDIO_I(sdio), .SDIO_O(sdio_o), .SDIO_OE(sdio_oe),
		.CONV_CLK(conv), .REF_ON(ref_on), .BIAS_ON(bias_on),
		.CLK_ON(clk_on), .READY(ready), .STAB_LOCKED(locked));
	scpc_clk_src u_scpc_clk_src (.sysref_go(go), .half_ns(half_ns),
		.nyq_clk(nyq), .hf_clk(hf), .sysref(sysref));

	// --------------------------------
	// helpers
	// --------------------------------
	task automatic final_report();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic to_fail();
		err_total++;
		final_report();
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic check(input string s, input logic [15:0] v,
		input logic [15:0] e);
		checks++;
		if (v !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %0h seen %0h", s, e, v);
		end
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// one serial frame, msb first, read data taken before each rise
	task automatic frame(input logic rd_bit, input logic [12:0] a,
		input logic [7:0] dv);
		logic [23:0] b;
		b = {rd_bit, 2'b00, a, dv};
		q = 8'h00;
		csb_n = 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			sdio_drv = b[i];
			cyc(5);
			if (i < 8)
				q[i] = sdio;
			if (i == 0 && rd_bit)
				check("oe", 16'(sdio_oe), 16'h1);
			sclk = 1'b1;
			cyc(4);
			sclk = 1'b0;
		end
		cyc(4);
		csb_n = 1'b1;
		cyc(8);
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] dv);
		frame(1'b0, a, dv);
		mdl[int'(a)] = int'(dv);
	endtask
	task automatic rd(input logic [12:0] a, input int e);
		frame(1'b1, a, 8'h00);
		check("rdata", 16'(q), 16'(e));
	endtask
	function automatic int m(input logic [12:0] a);
		return mdl.exists(int'(a)) ? mdl[int'(a)] : 0;
	endfunction
	// cycles up to the next conversion clock rise
	task automatic rise(output int c);
		c = 0;
		while (conv !== 1'b0 && c < 2000)
		begin
			cyc(1);
			c++;
		end
		while (conv !== 1'b1 && c < 2000)
		begin
			cyc(1);
			c++;
		end
		if (c >= 2000)
			to_fail();
	endtask
	// sample edges from strobe end to the next conversion rise
	task automatic sref(output int k);
		logic p, c;
		k = 0;
		n = 0;
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		while (sysref !== 1'b1 && n < 99)
		begin
			cyc(1);
			n++;
		end
		while (sysref !== 1'b0 && n < 99)
		begin
			cyc(1);
			n++;
		end
		if (n >= 99)
			to_fail();
		p = nyq;
		c = conv;
		while (n < 999)
		begin
			cyc(1);
			n++;
			if (nyq === 1'b1 && p === 1'b0)
				k++;
			if (conv === 1'b1 && c === 1'b0)
				break;
			p = nyq;
			c = conv;
		end
		if (n >= 999)
			to_fail();
	endtask

	// --------------------------------
	// stimulus
	// --------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// main sequence
	initial
	begin
		arst_n = 1'b0;
		sclk = 1'b0;
		csb_n = 1'b1;
		sdio_drv = 1'b0;
		pd_pin = 1'b0;
		go = 1'b0;
		half_ns = 8'h1E;
		err_total = 0;
		checks = 0;
		seed = 32'hD490E0ED;
		mdl[int'(ADDR_STABILIZER_EN)] = 1;
		repeat (6) @(posedge clk);
		#1;
		arst_n = 1'b1;
		cyc(10);
		check("awake", 16'({ref_on, bias_on, clk_on, ready}),
			16'hF);
		rd(ADDR_CLOCK_INPUT, m(ADDR_CLOCK_INPUT));
		rd(ADDR_DIVIDE_RATIO, m(ADDR_DIVIDE_RATIO));
		rd(ADDR_RESYNC_CONTROL, m(ADDR_RESYNC_CONTROL));
		rd(ADDR_STABILIZER_EN, m(ADDR_STABILIZER_EN));
		frame(1'b0, 13'h01F, 8'hA5);
		rd(13'h01F, 0);
		wr(ADDR_STABILIZER_EN, 8'h00);
		for (r = 1; r <= 8; r++)
		begin
			wr(ADDR_DIVIDE_RATIO, 8'(r - 1));
			rise(n);
			rise(n);
			rise(n);
			check("period", 16'(n), 16'(r * 6));
			rd(ADDR_CLOCK_STATUS, 12 + (r != 1));
			check("locked", 16'(locked), 16'h0);
		end
		wr(ADDR_CLOCK_INPUT, 8'h01);
		repeat (2)
		begin
			seed = lfsr(seed);
			r = int'(seed % 8) + 1;
			wr(ADDR_DIVIDE_RATIO, 8'(r - 1));
			rise(n);
			rise(n);
			rise(n);
			check("hf period", 16'(n), 16'(r * 24));
		end
		wr(ADDR_CLOCK_INPUT, 8'h00);
		half_ns = 8'h28;
		cyc(500);
		rise(n);
		rise(n);
		check("new rate", 16'(n), 16'(r * 8));
		wr(ADDR_DIVIDE_RATIO, 8'h07);
		wr(ADDR_RESYNC_CONTROL, 8'h02);
		sref(k1);
		seed = lfsr(seed);
		cyc(int'(seed % 37));
		sref(k2);
		check("resync every", 16'(k2), 16'(k1));
		wr(ADDR_RESYNC_CONTROL, 8'h04);
		sref(k2);
		check("resync once", 16'(k2), 16'(k1));
		rd(ADDR_RESYNC_CONTROL, m(ADDR_RESYNC_CONTROL) & 2);
		// fast input: stabilizer locks and retimes the falling edge
		half_ns = 8'h0A;
		r = 3;
		wr(ADDR_DIVIDE_RATIO, 8'(r - 1));
		cyc(200);
		rd(ADDR_CLOCK_STATUS, 11);
		check("lock", 16'(locked), 16'h1);
		rise(n);
		rise(n);
		check("fast period", 16'(n), 16'(r * 2));
		w = 0;
		while (conv === 1'b1 && w < 99)
		begin
			cyc(1);
			w++;
		end
		if (w >= 99)
			to_fail();
		check("duty", 16'(w), 16'(r * 2 / 2));
		for (i = 0; i < 2; i++)
		begin
			d = (i == 0) ? 40 : 400;
			pd_pin = 1'b1;
			cyc(8);
			check("pd", 16'({ref_on, bias_on, clk_on, ready, conv}),
				16'h0);
			cyc(d - 8);
			pd_pin = 1'b0;
			w = 0;
			while (ready !== 1'b1 && w < 3000)
			begin
				cyc(1);
				w++;
			end
			if (w >= 3000)
				to_fail();
			check("wake", 16'(w >= d / 4 - 4 && w <= d / 4 + 12),
				16'h1);
			check("resume", 16'(ref_on), 16'h1);
		end
		wr(ADDR_POWER_MODE, 8'h01);
		check("spi pd", 16'({ref_on, clk_on}), 16'h0);
		wr(ADDR_POWER_MODE, 8'h02);
		check("standby", 16'({ref_on, bias_on, clk_on, ready}),
			16'h8);
		rd(ADDR_POWER_MODE, m(ADDR_POWER_MODE));
		wr(ADDR_POWER_MODE, 8'h00);
		cyc(200);
		check("spi wake", 16'({ref_on, ready}), 16'h3);
		final_report();
	end
endmodule
